// >>> verilog/ced_controller.sv
// Configuration error demo controller: switches, detector control, LEDs, reconfig request
//
// Our own choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`include "ced_defs.svh"

module ced_controller #(
	parameter int unsigned STEP_CYCLES     = `CED_STEP_CYCLES,
	parameter int unsigned DEBOUNCE_CYCLES = `CED_DEBOUNCE_CYCLES
) (
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	input  wire logic [3:0]            mode_switch_bits,
	input  wire logic                  detect_start_button_n,
	input  wire logic                  force_error_button_n,
	input  wire logic                  det_error,
	input  wire logic                  det_done,
	output ced_pkg::ced_det_ctrl_t     det_ctrl,
	output logic                       reconfig_request_out,
	output logic                       reconfig_request_oe_n,
	output logic [5:0]                 activity_leds,
	output logic                       error_indicator_led,
	output logic                       enable_indicator_led,
	output logic                       irq,
	input  wire logic [7:0]            s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	input  wire logic [7:0]            s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	output logic [31:0]                s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready
);
	localparam int unsigned SW = $clog2(STEP_CYCLES + 1);
	localparam logic [SW-1:0] STEP_LAST = SW'(STEP_CYCLES - 1);
	localparam int unsigned RECONFIG_REQUEST_OUT_N = (`CED_RECONFIG_REQUEST_OUT_CYCLES < 1) ? 1 : `CED_RECONFIG_REQUEST_OUT_CYCLES;
	localparam logic [7:0] RECONFIG_REQUEST_OUT_LAST = 8'(RECONFIG_REQUEST_OUT_N - 1);

	logic [3:0]                 mode_s1_reg;
	logic [3:0]                 mode_s2_reg;
	logic                       err_s1_reg;
	logic                       err_s2_reg;
	logic                       done_s1_reg;
	logic                       done_s2_reg;
	logic [1:0]                 btn_held;
	logic [1:0]                 btn_press;
	logic                       start_held;
	logic                       start_press;
	logic                       force_press;
	logic                       en_reg;
	logic                       start_reg;
	logic                       force_reg;
	logic                       err_led_reg;
	logic                       blink_reg;
	logic [5:0]                 leds_reg;
	logic [SW-1:0]              step_cnt_reg;
	logic                       tick;
	ced_pkg::ced_det_state_t    ds_reg;
	ced_pkg::ced_rc_state_t     rc_reg;
	logic [7:0]                 rc_cnt_reg;
	logic                       sw_start_pulse;
	logic                       start_req;
	logic                       err_rise;
	logic [`CED_EV_W-1:0]       ev_set;
	logic [`CED_EV_W-1:0]       status_reg;
	logic [`CED_EV_W-1:0]       mask_reg;
	logic                       auto_reg;
	logic                       aw_hold_reg;
	logic                       w_hold_reg;
	logic [7:0]                 awaddr_reg;
	logic [31:0]                wdata_reg;
	logic [3:0]                 wstrb_reg;
	logic                       bvalid_reg;
	logic [1:0]                 bresp_reg;
	logic                       rvalid_reg;
	logic [1:0]                 rresp_reg;
	logic [31:0]                rdata_reg;
	logic                       wr_fire;
	logic                       wr_lane0;

	// Switch and detector inputs come from outside the clock domain
	always_ff @(posedge aclk or negedge aresetn) begin
		if (!aresetn) begin
			mode_s1_reg <= 4'h0;
			mode_s2_reg <= 4'h0;
			err_s1_reg  <= 1'b0;
			err_s2_reg  <= 1'b0;
			done_s1_reg <= 1'b0;
			done_s2_reg <= 1'b0;
		end else begin
			mode_s1_reg <= mode_switch_bits;
			mode_s2_reg <= mode_s1_reg;
			err_s1_reg  <= det_error;
			err_s2_reg  <= err_s1_reg;
			done_s1_reg <= det_done;
			done_s2_reg <= done_s1_reg;
		end
	end

	// Buttons: bit 0 start, bit 1 force
	ced_debounce #(
		.N           (2),
		.HOLD_CYCLES (DEBOUNCE_CYCLES)
	) u_buttons (
		.aclk    (aclk),
		.aresetn (aresetn),
		.raw_n   ({force_error_button_n, detect_start_button_n}),
		.held    (btn_held),
		.press   (btn_press)
	);

	assign start_held  = btn_held[0];
	assign start_press = btn_press[0];
	assign force_press = btn_press[1];
	assign start_req   = start_press | sw_start_pulse;
	assign err_rise    = err_s2_reg & !err_led_reg & !start_held & !start_press;

	// Detector enable follows the switch pattern; force only with full pattern
	always_ff @(posedge aclk or negedge aresetn) begin
		if (!aresetn) begin
			en_reg    <= 1'b0;
			force_reg <= 1'b0;
		end else begin
			en_reg    <= (mode_s2_reg[3:1] == `CED_EN_PATTERN);
			force_reg <= force_press && (mode_s2_reg == `CED_FORCE_PATTERN);
		end
	end

	// One start strobe per request; a second request during a running cycle is dropped
	always_ff @(posedge aclk or negedge aresetn) begin
		if (!aresetn) begin
			ds_reg    <= ced_pkg::DS_IDLE;
			start_reg <= 1'b0;
		end else begin
			start_reg <= 1'b0;
			case (ds_reg)
				ced_pkg::DS_IDLE: begin
					if (start_req && en_reg) begin
						start_reg <= 1'b1;
						ds_reg    <= ced_pkg::DS_RUN;
					end
				end
				ced_pkg::DS_RUN: begin
					if (done_s2_reg || !en_reg) begin
						ds_reg <= ced_pkg::DS_IDLE;
					end
				end
				default: begin
					ds_reg <= ced_pkg::DS_IDLE;
				end
			endcase
		end
	end

	assign det_ctrl.enable      = en_reg;
	assign det_ctrl.start       = start_reg;
	assign det_ctrl.force_error = force_reg;

	// Error LED: a start press clears it and masks the detector while held
	always_ff @(posedge aclk or negedge aresetn) begin
		if (!aresetn) begin
			err_led_reg <= 1'b0;
		end else if (start_press || start_held) begin
			err_led_reg <= 1'b0;
		end else if (err_s2_reg) begin
			err_led_reg <= 1'b1;
		end
	end

	// Reconfig pulse is finite so the shared pin and its manual button stay usable
	always_ff @(posedge aclk or negedge aresetn) begin
		if (!aresetn) begin
			rc_reg     <= ced_pkg::RC_IDLE;
			rc_cnt_reg <= 8'h00;
		end else begin
			case (rc_reg)
				ced_pkg::RC_IDLE: begin
					if (err_rise && auto_reg) begin
						rc_reg     <= ced_pkg::RC_DRIVE;
						rc_cnt_reg <= 8'h00;
					end
				end
				ced_pkg::RC_DRIVE: begin
					if (rc_cnt_reg == RECONFIG_REQUEST_OUT_LAST) begin
						rc_reg <= ced_pkg::RC_HOLD;
					end else begin
						rc_cnt_reg <= rc_cnt_reg + 8'h01;
					end
				end
				ced_pkg::RC_HOLD: begin
					// One request per error indication
					if (!err_led_reg) begin
						rc_reg <= ced_pkg::RC_IDLE;
					end
				end
				default: begin
					rc_reg <= ced_pkg::RC_IDLE;
				end
			endcase
		end
	end

	// Pin is released except while requesting; the jumper decides if it reaches the device
	assign reconfig_request_out  = 1'b0;
	assign reconfig_request_oe_n = (rc_reg != ced_pkg::RC_DRIVE);

	// Divider for the visible rate
	always_ff @(posedge aclk or negedge aresetn) begin
		if (!aresetn) begin
			step_cnt_reg <= '0;
		end else if (step_cnt_reg == STEP_LAST) begin
			step_cnt_reg <= '0;
		end else begin
			step_cnt_reg <= step_cnt_reg + 1'b1;
		end
	end

	assign tick = (step_cnt_reg == STEP_LAST);

	// Rotation and blink share the tick
	always_ff @(posedge aclk or negedge aresetn) begin
		if (!aresetn) begin
			leds_reg  <= `CED_LEDS_RESET;
			blink_reg <= 1'b0;
		end else begin
			if (tick) begin
				leds_reg <= {leds_reg[4:0], leds_reg[5]};
			end
			if (!en_reg) begin
				blink_reg <= 1'b0;
			end else if (tick) begin
				blink_reg <= !blink_reg;
			end
		end
	end

	assign activity_leds        = leds_reg;
	assign error_indicator_led  = err_led_reg;
	assign enable_indicator_led = blink_reg;

	// Sticky events
	assign ev_set[`CED_EV_ERROR_BIT] = err_rise;
	assign ev_set[`CED_EV_DONE_BIT]  = (ds_reg == ced_pkg::DS_RUN) && done_s2_reg;
	assign ev_set[`CED_EV_RECONFIG_REQUEST_OUT_BIT] = (rc_reg == ced_pkg::RC_IDLE) && err_rise && auto_reg;

	// Write side: address and data may arrive in either order
	assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
	assign s_axi_wready  = !w_hold_reg && !bvalid_reg;
	assign wr_fire       = aw_hold_reg && w_hold_reg && !bvalid_reg;
	assign wr_lane0      = wr_fire && wstrb_reg[0];

	always_ff @(posedge aclk or negedge aresetn) begin
		if (!aresetn) begin
			aw_hold_reg <= 1'b0;
			w_hold_reg  <= 1'b0;
			awaddr_reg  <= 8'h00;
			wdata_reg   <= 32'h0000_0000;
			wstrb_reg   <= 4'h0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= `CED_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_reg <= 1'b1;
				awaddr_reg  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_reg <= 1'b1;
				wdata_reg  <= s_axi_wdata;
				wstrb_reg  <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_hold_reg <= 1'b0;
				w_hold_reg  <= 1'b0;
				bvalid_reg  <= 1'b1;
				case (awaddr_reg)
					`CED_OFS_CTRL, `CED_OFS_STATUS, `CED_OFS_MASK, `CED_OFS_STATE: begin
						bresp_reg <= `CED_RESP_OKAY;
					end
					default: begin
						bresp_reg <= `CED_RESP_SLVERR;
					end
				endcase
			end else if (bvalid_reg && s_axi_bready) begin
				bvalid_reg <= 1'b0;
			end
		end
	end

	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp  = bresp_reg;

	// Control bits; the start bit is a self-clearing strobe
	always_ff @(posedge aclk or negedge aresetn) begin
		if (!aresetn) begin
			auto_reg       <= `CED_CTRL_RESET;
			sw_start_pulse <= 1'b0;
			mask_reg       <= '0;
		end else begin
			sw_start_pulse <= 1'b0;
			if (wr_lane0 && awaddr_reg == `CED_OFS_CTRL) begin
				auto_reg       <= wdata_reg[`CED_CTRL_AUTO_BIT];
				sw_start_pulse <= wdata_reg[`CED_CTRL_START_BIT];
			end
			if (wr_lane0 && awaddr_reg == `CED_OFS_MASK) begin
				mask_reg <= wdata_reg[`CED_EV_W-1:0];
			end
		end
	end

	// Write one clears; a new event in the same cycle wins
	always_ff @(posedge aclk or negedge aresetn) begin
		if (!aresetn) begin
			status_reg <= '0;
		end else if (wr_lane0 && awaddr_reg == `CED_OFS_STATUS) begin
			status_reg <= (status_reg & ~wdata_reg[`CED_EV_W-1:0]) | ev_set;
		end else begin
			status_reg <= status_reg | ev_set;
		end
	end

	assign irq = |(status_reg & mask_reg);

	// Read side: one outstanding read, answered the cycle after address
	assign s_axi_arready = !rvalid_reg;

	always_ff @(posedge aclk or negedge aresetn) begin
		if (!aresetn) begin
			rvalid_reg <= 1'b0;
			rresp_reg  <= `CED_RESP_OKAY;
			rdata_reg  <= 32'h0000_0000;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_reg <= 1'b1;
			rresp_reg  <= `CED_RESP_OKAY;
			case (s_axi_araddr)
				`CED_OFS_CTRL:   rdata_reg <= {31'h0000_0000, auto_reg};
				`CED_OFS_STATUS: rdata_reg <= {29'h0000_0000, status_reg};
				`CED_OFS_MASK:   rdata_reg <= {29'h0000_0000, mask_reg};
				`CED_OFS_STATE: begin
					rdata_reg <= {16'h0000, mode_s2_reg, 1'b0, rc_reg, ds_reg,
						blink_reg, err_led_reg, leds_reg};
				end
				default: begin
					rdata_reg <= 32'h0000_0000;
					rresp_reg <= `CED_RESP_SLVERR;
				end
			endcase
		end else if (rvalid_reg && s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end
	end

	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rresp  = rresp_reg;
	assign s_axi_rdata  = rdata_reg;

	// Checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_enable_pattern : assert property (##1 en_reg == ($past(mode_s2_reg[3:1]) == 3'h6))
		else $error("Detector enable does not follow switch pattern");
	a_blink_off : assert property (!en_reg |=> !blink_reg)
		else $error("Enable LED blinks while detector disabled");
	a_start_once : assert property (start_reg |=> !start_reg && ds_reg == ced_pkg::DS_RUN)
		else $error("Start strobe not a single cycle");
	a_start_cause : assert property (
		(ds_reg == ced_pkg::DS_IDLE && start_req && en_reg) |=> start_reg)
		else $error("Start request did not start a cycle");
	a_force_gate : assert property (force_reg |-> $past(mode_s2_reg) == 4'hD)
		else $error("Force without the force pattern");
	a_err_led_set : assert property (err_s2_reg && !start_held && !start_press
		|=> err_led_reg)
		else $error("Error LED not lit on reported error");
	a_err_led_clear : assert property (start_press |=> !err_led_reg)
		else $error("Start press did not clear error LED");
	a_reconfig_request_out_pulse : assert property ($fell(reconfig_request_oe_n)
		|-> !reconfig_request_oe_n [*8])
		else $error("Reconfiguration request too short");
	a_reconfig_request_out_hiz : assert property (!reconfig_request_oe_n |-> rc_reg == ced_pkg::RC_DRIVE
		&& $past(err_led_reg || err_rise))
		else $error("Request pin driven outside a request");
	a_leds_rotate : assert property (tick |=> activity_leds == {$past(activity_leds[4:0]),
		$past(activity_leds[5])} && $onehot(activity_leds))
		else $error("Activity LEDs not rotating one-hot");

	c_start : cover property (start_reg ##[1:1000] done_s2_reg);
	c_force : cover property (force_reg ##[1:20] err_led_reg);
	c_reconfig_request_out : cover property ($fell(reconfig_request_oe_n));
	c_irq   : cover property ($rose(irq));

endmodule : ced_controller

// >>> verilog/ced_defs.svh
// Offsets, field positions, reset values and timing counts of the demo controller
`ifndef CED_DEFS_SVH
`define CED_DEFS_SVH

// Clock and visible rates
`define CED_CLK_HZ            12000000
`define CED_STEP_MS           250
`define CED_STEP_CYCLES       (`CED_CLK_HZ / 1000 * `CED_STEP_MS)
`define CED_DEBOUNCE_MS       10
`define CED_DEBOUNCE_CYCLES   (`CED_CLK_HZ / 1000 * `CED_DEBOUNCE_MS)
`define CED_RECONFIG_REQUEST_OUT_NS          1000
`define CED_RECONFIG_REQUEST_OUT_CYCLES      ((`CED_CLK_HZ / 1000 * `CED_RECONFIG_REQUEST_OUT_NS + 999999) / 1000000)

// Register byte offsets
`define CED_OFS_CTRL          8'h00
`define CED_OFS_STATUS        8'h04
`define CED_OFS_MASK          8'h08
`define CED_OFS_STATE         8'h0C

// Control register fields and reset value
`define CED_CTRL_AUTO_BIT     0
`define CED_CTRL_START_BIT    1
`define CED_CTRL_RESET        1'b1

// Status and mask fields
`define CED_EV_ERROR_BIT      0
`define CED_EV_DONE_BIT       1
`define CED_EV_RECONFIG_REQUEST_OUT_BIT      2
`define CED_EV_W              3

// Switch patterns
`define CED_EN_PATTERN        3'h6
`define CED_FORCE_PATTERN     4'hD

// Bus responses and reset values
`define CED_RESP_OKAY         2'h0
`define CED_RESP_SLVERR       2'h2
`define CED_LEDS_RESET        6'h01

`endif

// >>> verilog/ced_pkg.sv
// Types shared by the demo controller files
package ced_pkg;

	// Control lines toward the on-chip configuration error detector
	typedef struct packed {
		logic enable;
		logic start;
		logic force_error;
	} ced_det_ctrl_t;

	// Detection sequence
	typedef enum logic [0:0] {
		DS_IDLE,
		DS_RUN
	} ced_det_state_t;

	// Reconfiguration request sequence
	typedef enum logic [1:0] {
		RC_IDLE,
		RC_DRIVE,
		RC_HOLD
	} ced_rc_state_t;

endpackage : ced_pkg

// >>> verilog/ced_debounce.sv
// Button synchroniser, debouncer and press-edge detector
`timescale 1ns/10ps
`include "ced_defs.svh"

module ced_debounce #(
	parameter int unsigned N           = 2,
	parameter int unsigned HOLD_CYCLES = `CED_DEBOUNCE_CYCLES
) (
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic [N-1:0] raw_n,
	output logic      [N-1:0] held,
	output logic      [N-1:0] press
);
	localparam int unsigned CW = $clog2(HOLD_CYCLES + 1);
	localparam logic [CW-1:0] LAST = CW'(HOLD_CYCLES - 1);

	genvar i;
	generate
		for (i = 0; i < N; i++) begin : g_btn
			logic          sync1_reg;
			logic          sync2_reg;
			logic [CW-1:0] cnt_reg;
			logic          held_reg;
			logic          press_reg;

			// Two flops before anything looks at the pin
			always_ff @(posedge aclk or negedge aresetn) begin
				if (!aresetn) begin
					sync1_reg <= 1'b1;
					sync2_reg <= 1'b1;
				end else begin
					sync1_reg <= raw_n[i];
					sync2_reg <= sync1_reg;
				end
			end

			// Level must stay changed for the full hold time; bounce restarts it
			always_ff @(posedge aclk or negedge aresetn) begin
				if (!aresetn) begin
					cnt_reg   <= '0;
					held_reg  <= 1'b0;
					press_reg <= 1'b0;
				end else begin
					press_reg <= 1'b0;
					if (!sync2_reg != held_reg) begin
						if (cnt_reg == LAST) begin
							cnt_reg   <= '0;
							held_reg  <= !sync2_reg;
							press_reg <= !sync2_reg;
						end else begin
							cnt_reg <= cnt_reg + 1'b1;
						end
					end else begin
						cnt_reg <= '0;
					end
				end
			end

			assign held[i]  = held_reg;
			assign press[i] = press_reg;

			a_press_single : assert property (@(posedge aclk) disable iff (!aresetn)
				press_reg |=> !press_reg)
				else $error("Press pulse longer than one cycle");
		end
	endgenerate

endmodule : ced_debounce

// >>> tb/ced_detector_model.sv
// Behavioural model of the on-chip configuration error detector
`timescale 1ns/10ps

module ced_detector_model #(
	parameter int unsigned LATENCY = 5
) (
	input  wire logic                   aclk,
	input  wire ced_pkg::ced_det_ctrl_t det_ctrl,
	input  wire logic                   inject,
	input  wire logic                   program_pin_n,
	output logic                        det_error,
	output logic                        det_done
);
	logic       pending_reg = 1'b0;
	logic       busy_reg    = 1'b0;
	logic       err_reg     = 1'b0;
	logic       done_reg    = 1'b0;
	logic [7:0] count_reg   = 8'h00;

	assign det_error = err_reg;
	assign det_done  = done_reg;

	// Memory fault stays until the program pin is really pulled low
	always @(posedge aclk) begin
		if (program_pin_n === 1'b0) pending_reg <= 1'b0;
		else if (inject) pending_reg <= 1'b1;
	end

	// One detection cycle per start; a forced error is reported at once
	always @(posedge aclk) begin
		done_reg <= 1'b0;
		if (det_ctrl.force_error === 1'b1) err_reg <= 1'b1;
		if (det_ctrl.start === 1'b1 && det_ctrl.enable === 1'b1) begin
			busy_reg  <= 1'b1;
			count_reg <= 8'h00;
			err_reg   <= 1'b0;
		end else if (busy_reg) begin
			count_reg <= count_reg + 8'h01;
			if (count_reg == 8'(LATENCY - 1)) begin
				busy_reg <= 1'b0;
				done_reg <= 1'b1;
				err_reg  <= pending_reg;
			end
		end
	end
endmodule : ced_detector_model

// >>> tb/config_error_demo_controller_test.sv
// Self-checking bench for the demo controller against a detector model
`timescale 1ns/10ps
`include "ced_defs.svh"

module config_error_demo_controller_test;
	localparam int unsigned STEP = 8;
	localparam logic [33:0] IDLE = 34'h0000_0082; // Leds 01, all else idle, pin released
	logic        aclk = 1'b0, aresetn = 1'b0, start_n = 1'b1, force_n = 1'b1;
	logic [3:0]  sw = 4'hF;
	logic        jumper = 1'b1, inject = 1'b0, det_error, det_done;
	ced_pkg::ced_det_ctrl_t det_ctrl;
	logic        rc_out, rc_oe_n, err_led, en_led, irq;
	logic [5:0]  leds;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000, rdata;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp;
	wire         program_pin_n;
	int          miscompares = 0, checked = 0, starts = 0, forces = 0, run = 0, last_run = 0;

	// Pulled-up pin, driven low only through the fitted jumper
	assign program_pin_n = (jumper && rc_oe_n === 1'b0) ? rc_out : 1'b1;
	always #41.67 aclk = ~aclk; // 12 MHz

	ced_controller #(.STEP_CYCLES(STEP), .DEBOUNCE_CYCLES(4)) DUT (
		.aclk(aclk), .aresetn(aresetn), .mode_switch_bits(sw),
		.detect_start_button_n(start_n), .force_error_button_n(force_n),
		.det_error(det_error), .det_done(det_done), .det_ctrl(det_ctrl),
		.reconfig_request_out(rc_out), .reconfig_request_oe_n(rc_oe_n),
		.activity_leds(leds), .error_indicator_led(err_led),
		.enable_indicator_led(en_led), .irq(irq),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
	);
	ced_detector_model #(.LATENCY(5)) detector (
		.aclk(aclk), .det_ctrl(det_ctrl), .inject(inject), .program_pin_n(program_pin_n),
		.det_error(det_error), .det_done(det_done)
	);

	// Pulse counters and length of the last reconfiguration request
	always @(posedge aclk) begin
		if (det_ctrl.start === 1'b1) starts++;
		if (det_ctrl.force_error === 1'b1) forces++;
		if (rc_oe_n === 1'b0) run++;
		else if (run != 0) begin
			last_run = run;
			run = 0;
		end
	end

	function automatic logic [33:0] outs();
		return 34'({leds, err_led, en_led, det_ctrl, rc_oe_n, irq});
	endfunction : outs

	task automatic cmp(input logic [33:0] got, input logic [33:0] exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp

	task automatic tick(input int n);
		repeat (n) @(posedge aclk);
	endtask : tick

	task close_out;
		$display("checked=%0d miscompares=%0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : close_out

	// Button held long enough to pass the debouncer, then released and settled
	task automatic push(input logic f);
		if (f) force_n <= 1'b0;
		else start_n <= 1'b0;
		tick(16);
	endtask : push
	task automatic lift;
		start_n <= 1'b1;
		force_n <= 1'b1;
		tick(24);
	endtask : lift

	// Master holds each channel until its ready, then waits for the answer
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw_ok, w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge aclk);
			if (!aw_ok && awready === 1'b1) begin
				aw_ok = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w_ok && wready === 1'b1) begin
				w_ok = 1'b1;
				wvalid <= 1'b0;
			end
		end
		while (bvalid !== 1'b1) @(posedge aclk);
		r = bresp;
		bready <= 1'b0;
		tick(1); // Gap so the next call never re-raises bready in this time step
	endtask : axi_wr
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		tick(1); // Gap so the next call never re-raises rready in this time step
	endtask : axi_rd
	task automatic wr_chk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		logic [1:0] r;
		axi_wr(a, d, r);
		cmp(34'(r), 34'(e));
	endtask : wr_chk
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [33:0] e);
		logic [31:0] d;
		logic [1:0]  r;
		axi_rd(a, d, r);
		cmp({r, d & m}, e);
	endtask : rd_chk

	task automatic t_rotate;
		logic [5:0] x;
		for (int i = 0; i < 6; i++) begin
			x = leds;
			tick(STEP);
			cmp(34'(leds), 34'({x[4:0], x[5]}));
		end
		$display("test rotate done");
	endtask : t_rotate

	// Every switch pattern: enable and blinking only for 110x
	task automatic t_enable;
		int   tog;
		logic b;
		for (int i = 0; i < 16; i++) begin
			sw <= i[3:0];
			tick(6);
			cmp(34'(det_ctrl.enable), 34'(i[3:1] == 3'b110));
			tog = 0;
			b = en_led;
			repeat (3 * STEP) begin
				tick(1);
				if (en_led !== b) tog++;
				b = en_led;
			end
			cmp(34'(tog != 0), 34'(i[3:1] == 3'b110));
		end
		$display("test enable done");
	endtask : t_enable

	task automatic t_force;
		int f;
		f = forces;
		sw <= 4'hC;
		push(1'b1);
		lift;
		cmp(34'(forces - f), 34'h0);
		cmp(34'(err_led), 34'h0);
		sw <= 4'hD;
		last_run = 0;
		tick(4);
		push(1'b1);
		cmp(34'(err_led), 34'h1);
		lift;
		cmp(34'(forces - f), 34'h1);
		cmp(34'(err_led), 34'h1);
		cmp(34'(last_run), 34'(`CED_RECONFIG_REQUEST_OUT_CYCLES));
		cmp(34'(rc_oe_n), 34'h1);
		$display("test force done");
	endtask : t_force

	// Reset acts at once, without waiting for a clock edge
	task automatic t_async;
		@(posedge aclk);
		#10 aresetn = 1'b0;
		#1 cmp(outs(), IDLE);
		tick(12);
		aresetn <= 1'b1;
		// Model still reports the forced error: let the request it causes run out
		tick(24);
		$display("test async done");
	endtask : t_async

	task automatic t_start;
		int s;
		sw <= 4'hF;
		tick(4);
		s = starts;
		push(1'b0);
		lift;
		cmp(34'(starts - s), 34'h0);
		sw <= 4'hD;
		tick(4);
		s = starts;
		push(1'b0);
		cmp(34'(err_led), 34'h0);
		lift;
		cmp(34'(starts - s), 34'h1);
		cmp(34'(err_led), 34'h0);
		$display("test start done");
	endtask : t_start

	// Injected fault: stays without the jumper, corrected with it
	task automatic t_inject;
		jumper <= 1'b0;
		inject <= 1'b1;
		last_run = 0;
		tick(1);
		inject <= 1'b0;
		push(1'b0);
		cmp(34'(err_led), 34'h0);
		lift;
		cmp(34'(err_led), 34'h1);
		cmp(34'(last_run), 34'(`CED_RECONFIG_REQUEST_OUT_CYCLES));
		push(1'b0);
		lift;
		cmp(34'(err_led), 34'h1);
		jumper <= 1'b1;
		push(1'b0);
		lift;
		cmp(34'(err_led), 34'h1);
		push(1'b0);
		lift;
		cmp(34'(err_led), 34'h0);
		$display("test inject done");
	endtask : t_inject

	task automatic t_axi;
		int s;
		rd_chk(8'h00, 32'hFFFF_FFFF, 34'h0_0000_0001);
		rd_chk(8'h10, 32'hFFFF_FFFF, 34'h2_0000_0000);
		wr_chk(8'h10, 32'h0000_0001, 2'h2);
		rd_chk(8'h0C, 32'h0000_F000, 34'h0_0000_D000);
		wr_chk(8'h04, 32'h0000_0007, 2'h0);
		rd_chk(8'h04, 32'h0000_0007, 34'h0_0000_0000);
		rd_chk(8'h08, 32'hFFFF_FFFF, 34'h0_0000_0000);
		push(1'b1);
		lift;
		rd_chk(8'h04, 32'h0000_0007, 34'h0_0000_0005);
		cmp(34'(irq), 34'h0);
		wr_chk(8'h08, 32'h0000_0001, 2'h0);
		tick(1);
		cmp(34'(irq), 34'h1);
		wr_chk(8'h04, 32'h0000_0001, 2'h0);
		tick(1);
		cmp(34'(irq), 34'h0);
		rd_chk(8'h04, 32'h0000_0007, 34'h0_0000_0004);
		s = starts;
		wr_chk(8'h00, 32'h0000_0003, 2'h0);
		tick(16);
		cmp(34'(starts - s), 34'h1);
		rd_chk(8'h04, 32'h0000_0002, 34'h0_0000_0002);
		wr_chk(8'h08, 32'h0000_0000, 2'h0);
		$display("test axi done");
	endtask : t_axi

	// Main sequence
	initial begin
		tick(12);
		cmp(outs(), IDLE);
		cmp(34'({awready, wready, arready, bvalid, rvalid}), 34'h1C);
		$display("test reset done");
		aresetn <= 1'b1;
		tick(4);
		t_rotate;
		t_enable;
		t_force;
		t_async;
		t_start;
		t_inject;
		t_axi;
		close_out;
	end

	// Watchdog well beyond the expected run
	initial begin
		repeat (20000) @(posedge aclk);
		miscompares++;
		close_out;
	end
endmodule : config_error_demo_controller_test
